// ===== cfg_host_model.sv
// Purpose: host side of the register port, one byte per access
// Assumes: strobes change at the falling clock edge
// Notes: idle lines show the inverse of the last value, not a held copy
module cfg_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic wr_en_o,
  output logic [4:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  output logic [4:0] rd_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet port at time zero
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 5'h00;
    wr_data_o = 8'h00;
    rd_en_o = 1'b0;
    rd_addr_o = 5'h00;
  end
  // Single-cycle write strobe
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~wr_addr_o;
    wr_data_o = ~wr_data_o;
  endtask : write_reg
  // Read strobe, then a bounded wait for the data flag
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~rd_addr_o;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        d = rd_data_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : read_reg
endmodule : cfg_host_model

// ===== dac_cfg_pkg.sv
// Purpose: shared constants and carriers for the converter config bank
// Assumes: byte-wide registers on a 5-bit internal register port
// Notes: masks give the bits that hold state; others read as zero
package dac_cfg_pkg;

  // Register addresses
  localparam logic [4:0] ADDR_PWR = 5'h06;
  localparam logic [4:0] ADDR_GAIN = 5'h07;
  localparam logic [4:0] ADDR_DLL_RST = 5'h08;
  localparam logic [4:0] ADDR_PLL_DIV = 5'h09;
  localparam logic [4:0] ADDR_DLL_TUNE = 5'h0A;
  localparam logic [4:0] ADDR_PLL_TUNE = 5'h0B;
  localparam logic [4:0] ADDR_OFS_A_HI = 5'h0C;
  localparam logic [4:0] ADDR_OFS_A_LO = 5'h0D;
  localparam logic [4:0] ADDR_OFS_B_HI = 5'h0E;
  localparam logic [4:0] ADDR_OFS_B_LO = 5'h0F;

  // Reset values
  localparam logic [7:0] RST_PWR = 8'h0C;
  localparam logic [7:0] RST_GAIN = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Bits that hold state; reserved and unused bits read zero
  localparam logic [7:0] MASK_PWR = 8'h3F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_DLL_RST = 8'h04;
  localparam logic [7:0] MASK_OFS_A_HI = 8'h3F;
  localparam logic [7:0] MASK_OFS_B_HI = 8'h1F;

  // Power register fields
  localparam int PWR_SLEEP_B = 5;
  localparam int PWR_SLEEP_A = 4;
  localparam int PWR_CORNER_A = 3;
  localparam int PWR_CORNER_B = 2;
  localparam int PWR_PLL_SLEEP = 1;
  localparam int PWR_DLL_SLEEP = 0;

  // Other single-bit fields
  localparam int DLL_RST_BIT = 2;
  localparam int DLL_INVCLK_BIT = 3;
  localparam int PLL_LF_RST_BIT = 7;
  localparam int PLL_HALF_BIT = 6;
  localparam int OFS_SYNC_BIT = 5;

  // Field widths
  localparam int SCALE_W = 4;
  localparam int PLL_M_W = 5;
  localparam int PLL_N_W = 3;
  localparam int DLY_W = 4;
  localparam int IFIX_W = 3;
  localparam int OFS_W = 13;
  localparam int OFS_HI_W = 5;

  // Delay adjust: degrees at code zero and per step
  localparam int DLY_CENTER_DEG = 90;
  localparam int DLY_STEP_DEG = 5;
  // Delay-line bias code that must never be used
  localparam logic [2:0] IFIX_FORBIDDEN = 3'h4;

  // Per-channel converter controls
  typedef struct packed {
    logic sleep;
    logic bias_corner_sel;
    logic [SCALE_W-1:0] current_scale;
    logic [SCALE_W:0] scale_steps;
  } chan_ctrl_t;

  // Delay-locked loop controls
  typedef struct packed {
    logic sleep;
    logic restart;
    logic filter_discharge;
    logic mid_bias;
    logic [DLY_W-1:0] delay_code;
    logic [7:0] delay_deg;
    logic invclk;
    logic [IFIX_W-1:0] ifixed;
    logic ifixed_illegal;
  } dll_ctrl_t;

  // Clock multiplier controls
  typedef struct packed {
    logic sleep;
    logic loop_filter_discharge;
    logic oscillator_halving;
    logic [1:0] post_div;
    logic [1:0] gain;
    logic [3:0] range;
    logic [PLL_M_W:0] mult;
    logic mult_valid;
    logic [PLL_N_W:0] div;
    logic div_valid;
  } pll_ctrl_t;

endpackage : dac_cfg_pkg

// ===== dac_power_clock_offset_regs.sv
// Purpose: power, gain, delay loop, clock multiplier and offset config
// Assumes: write and read strobes come from the serial port logic
// Notes: controls follow a write two clock edges later
module dac_power_clock_offset_regs (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [4:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic dll_lock_raw_i,
  output logic dll_lock_o,
  output dac_cfg_pkg::chan_ctrl_t chan_a_ctrl_o,
  output dac_cfg_pkg::chan_ctrl_t chan_b_ctrl_o,
  output dac_cfg_pkg::dll_ctrl_t dll_ctrl_o,
  output dac_cfg_pkg::pll_ctrl_t pll_ctrl_o,
  output logic [dac_cfg_pkg::OFS_W-1:0] chan_a_offset_o,
  output logic [dac_cfg_pkg::OFS_W-1:0] chan_b_offset_o
);

  // Byte registers of the bank
  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] gain;
    logic [7:0] dll_rst;
    logic [7:0] pll_div;
    logic [7:0] dll_tune;
    logic [7:0] pll_tune;
    logic [7:0] ofs_a_hi;
    logic [7:0] ofs_a_lo;
    logic [7:0] ofs_b_hi;
    logic [7:0] ofs_b_lo;
  } bank_t;

  // Module state apart from the working offsets, which sit in offset_hold
  typedef struct packed {
    bank_t bank;
    logic [7:0] rd_data;
    logic rd_valid;
    logic lock_meta;
    logic lock_sync;
    logic dll_lock;
    logic ofs_load;
    dac_cfg_pkg::chan_ctrl_t chan_a;
    dac_cfg_pkg::chan_ctrl_t chan_b;
    dac_cfg_pkg::dll_ctrl_t dll;
    dac_cfg_pkg::pll_ctrl_t pll;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [dac_cfg_pkg::PLL_M_W:0] mult_val;
  logic mult_ok;
  logic [dac_cfg_pkg::PLL_N_W:0] div_val;
  logic div_ok;
  logic [dac_cfg_pkg::OFS_W-1:0] staged_a;
  logic [dac_cfg_pkg::OFS_W-1:0] staged_b;
  logic signed [9:0] delay_deg_s;

  // Thermometer decoders for the M and N dividers
  therm_decode #(
    .CODE_W(dac_cfg_pkg::PLL_M_W)
  ) u_mult_dec (
    .code_i(state_reg.bank.pll_div[7:3]),
    .value_o(mult_val),
    .valid_o(mult_ok)
  );

  therm_decode #(
    .CODE_W(dac_cfg_pkg::PLL_N_W)
  ) u_div_dec (
    .code_i(state_reg.bank.pll_div[2:0]),
    .value_o(div_val),
    .valid_o(div_ok)
  );

  // Staged offsets assembled from high and low bytes
  assign staged_a = {state_reg.bank.ofs_a_hi[dac_cfg_pkg::OFS_HI_W-1:0],
                     state_reg.bank.ofs_a_lo};
  assign staged_b = {state_reg.bank.ofs_b_hi[dac_cfg_pkg::OFS_HI_W-1:0],
                     state_reg.bank.ofs_b_lo};

  // Working offsets, loaded together on one pulse
  offset_hold #(
    .W(dac_cfg_pkg::OFS_W)
  ) u_ofs_a (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(state_reg.ofs_load),
    .staged_i(staged_a),
    .held_o(chan_a_offset_o)
  );

  offset_hold #(
    .W(dac_cfg_pkg::OFS_W)
  ) u_ofs_b (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(state_reg.ofs_load),
    .staged_i(staged_b),
    .held_o(chan_b_offset_o)
  );

  // Delay adjust in degrees: signed code times step about centre
  assign delay_deg_s = 10'(dac_cfg_pkg::DLY_CENTER_DEG)
                     + 10'(dac_cfg_pkg::DLY_STEP_DEG)
                     * 10'($signed(state_reg.bank.dll_tune[7:4]));

  // Next-state logic: writes, reads, lock sync and decoded controls
  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    state_next.ofs_load = 1'b0;

    // Register writes; masks keep reserved bits at zero
    if (wr_en_i) begin
      unique case (wr_addr_i)
        dac_cfg_pkg::ADDR_PWR: begin
          state_next.bank.pwr = wr_data_i & dac_cfg_pkg::MASK_PWR;
        end
        dac_cfg_pkg::ADDR_GAIN: begin
          state_next.bank.gain = wr_data_i;
        end
        dac_cfg_pkg::ADDR_DLL_RST: begin
          state_next.bank.dll_rst = wr_data_i & dac_cfg_pkg::MASK_DLL_RST;
        end
        dac_cfg_pkg::ADDR_PLL_DIV: begin
          state_next.bank.pll_div = wr_data_i;
        end
        dac_cfg_pkg::ADDR_DLL_TUNE: begin
          state_next.bank.dll_tune = wr_data_i;
        end
        dac_cfg_pkg::ADDR_PLL_TUNE: begin
          state_next.bank.pll_tune = wr_data_i;
        end
        dac_cfg_pkg::ADDR_OFS_A_HI: begin
          // Strobe keeps its written value, no self-clear
          state_next.bank.ofs_a_hi = wr_data_i & dac_cfg_pkg::MASK_OFS_A_HI;
          // Only a zero-to-one change of the strobe transfers
          state_next.ofs_load = wr_data_i[dac_cfg_pkg::OFS_SYNC_BIT]
            & ~state_reg.bank.ofs_a_hi[dac_cfg_pkg::OFS_SYNC_BIT];
        end
        dac_cfg_pkg::ADDR_OFS_A_LO: begin
          state_next.bank.ofs_a_lo = wr_data_i;
        end
        dac_cfg_pkg::ADDR_OFS_B_HI: begin
          state_next.bank.ofs_b_hi = wr_data_i & dac_cfg_pkg::MASK_OFS_B_HI;
        end
        dac_cfg_pkg::ADDR_OFS_B_LO: begin
          state_next.bank.ofs_b_lo = wr_data_i;
        end
        default: begin
          // Writes elsewhere are not this bank's and are dropped
        end
      endcase
    end

    // Register reads; unmapped addresses answer zero
    if (rd_en_i) begin
      state_next.rd_valid = 1'b1;
      unique case (rd_addr_i)
        dac_cfg_pkg::ADDR_PWR: state_next.rd_data = state_reg.bank.pwr;
        dac_cfg_pkg::ADDR_GAIN: state_next.rd_data = state_reg.bank.gain;
        dac_cfg_pkg::ADDR_DLL_RST: state_next.rd_data = state_reg.bank.dll_rst;
        dac_cfg_pkg::ADDR_PLL_DIV: state_next.rd_data = state_reg.bank.pll_div;
        dac_cfg_pkg::ADDR_DLL_TUNE: state_next.rd_data = state_reg.bank.dll_tune;
        dac_cfg_pkg::ADDR_PLL_TUNE: state_next.rd_data = state_reg.bank.pll_tune;
        dac_cfg_pkg::ADDR_OFS_A_HI: state_next.rd_data = state_reg.bank.ofs_a_hi;
        dac_cfg_pkg::ADDR_OFS_A_LO: state_next.rd_data = state_reg.bank.ofs_a_lo;
        dac_cfg_pkg::ADDR_OFS_B_HI: state_next.rd_data = state_reg.bank.ofs_b_hi;
        dac_cfg_pkg::ADDR_OFS_B_LO: state_next.rd_data = state_reg.bank.ofs_b_lo;
        default: state_next.rd_data = dac_cfg_pkg::RST_ZERO;
      endcase
    end

    // Lock indicator comes from the analog loop; two flops first
    state_next.lock_meta = dll_lock_raw_i;
    state_next.lock_sync = state_reg.lock_meta;
    // Restart wins over a stale lock from before the restart
    state_next.dll_lock = state_reg.lock_sync
      & ~state_reg.bank.dll_rst[dac_cfg_pkg::DLL_RST_BIT];

    // Channel A converter controls
    state_next.chan_a.sleep =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_SLEEP_A];
    state_next.chan_a.bias_corner_sel =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_CORNER_A];
    state_next.chan_a.current_scale = state_reg.bank.gain[7:4];
    state_next.chan_a.scale_steps =
      {1'b0, state_reg.bank.gain[7:4]} + 5'h01;

    // Channel B converter controls
    state_next.chan_b.sleep =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_SLEEP_B];
    state_next.chan_b.bias_corner_sel =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_CORNER_B];
    state_next.chan_b.current_scale = state_reg.bank.gain[3:0];
    state_next.chan_b.scale_steps =
      {1'b0, state_reg.bank.gain[3:0]} + 5'h01;

    // Delay-locked loop controls
    state_next.dll.sleep =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_DLL_SLEEP];
    state_next.dll.restart =
      state_reg.bank.dll_rst[dac_cfg_pkg::DLL_RST_BIT];
    // Filter held discharged and line at mid bias while restarting
    state_next.dll.filter_discharge =
      state_reg.bank.dll_rst[dac_cfg_pkg::DLL_RST_BIT];
    state_next.dll.mid_bias =
      state_reg.bank.dll_rst[dac_cfg_pkg::DLL_RST_BIT];
    state_next.dll.delay_code = state_reg.bank.dll_tune[7:4];
    state_next.dll.delay_deg = delay_deg_s[7:0];
    state_next.dll.invclk =
      state_reg.bank.dll_tune[dac_cfg_pkg::DLL_INVCLK_BIT];
    state_next.dll.ifixed = state_reg.bank.dll_tune[2:0];
    // Forbidden code still passes, but is flagged for the analog side
    state_next.dll.ifixed_illegal =
      (state_reg.bank.dll_tune[2:0] == dac_cfg_pkg::IFIX_FORBIDDEN);

    // Clock multiplier controls
    state_next.pll.sleep =
      state_reg.bank.pwr[dac_cfg_pkg::PWR_PLL_SLEEP];
    state_next.pll.loop_filter_discharge =
      state_reg.bank.pll_tune[dac_cfg_pkg::PLL_LF_RST_BIT];
    state_next.pll.oscillator_halving =
      state_reg.bank.pll_tune[dac_cfg_pkg::PLL_HALF_BIT];
    state_next.pll.post_div =
      state_reg.bank.pll_tune[dac_cfg_pkg::PLL_HALF_BIT] ? 2'h2 : 2'h1;
    state_next.pll.gain = state_reg.bank.pll_tune[5:4];
    state_next.pll.range = state_reg.bank.pll_tune[3:0];
    // Oscillator ratio M over N; invalid codes give zero and no valid
    state_next.pll.mult = mult_val;
    state_next.pll.mult_valid = mult_ok;
    state_next.pll.div = div_val;
    state_next.pll.div_valid = div_ok;
  end

  // State register; reset restores every listed default
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.bank.pwr <= dac_cfg_pkg::RST_PWR;
      state_reg.bank.gain <= dac_cfg_pkg::RST_GAIN;
      state_reg.chan_a.bias_corner_sel <= 1'b1;
      state_reg.chan_b.bias_corner_sel <= 1'b1;
      state_reg.chan_a.current_scale <= 4'hF;
      state_reg.chan_b.current_scale <= 4'hF;
      state_reg.chan_a.scale_steps <= 5'h10;
      state_reg.chan_b.scale_steps <= 5'h10;
      state_reg.dll.delay_deg <= 8'h5A;
      state_reg.pll.post_div <= 2'h1;
      state_reg.pll.mult <= 6'h01;
      state_reg.pll.mult_valid <= 1'b1;
      state_reg.pll.div <= 4'h1;
      state_reg.pll.div_valid <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data_o = state_reg.rd_data;
  assign rd_valid_o = state_reg.rd_valid;
  assign dll_lock_o = state_reg.dll_lock;
  assign chan_a_ctrl_o = state_reg.chan_a;
  assign chan_b_ctrl_o = state_reg.chan_b;
  assign dll_ctrl_o = state_reg.dll;
  assign pll_ctrl_o = state_reg.pll;

endmodule : dac_power_clock_offset_regs

// ===== dac_power_clock_offset_regs_properties.sv
// Purpose: assertions on the config bank outputs
// Assumes: decoded controls follow a write two edges later
// Notes: bound to every instance of the bank
module cfg_bank_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic dll_lock_o,
  input wire dac_cfg_pkg::chan_ctrl_t chan_a_ctrl_o,
  input wire dac_cfg_pkg::chan_ctrl_t chan_b_ctrl_o,
  input wire dac_cfg_pkg::dll_ctrl_t dll_ctrl_o,
  input wire dac_cfg_pkg::pll_ctrl_t pll_ctrl_o,
  input wire logic [12:0] chan_a_offset_o,
  input wire logic [12:0] chan_b_offset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Power byte fields reach the converters and both clock loops two edges after the write
  a_sleep_follow: assert property (
    wr_en_i && wr_addr_i == 5'h06 |-> ##2
    {chan_b_ctrl_o.sleep, chan_a_ctrl_o.sleep} == $past(wr_data_i[5:4], 2))
    else $error("converter sleep wrong");
  a_corner_follow: assert property (
    wr_en_i && wr_addr_i == 5'h06 |-> ##2
    {chan_a_ctrl_o.bias_corner_sel, chan_b_ctrl_o.bias_corner_sel} == $past(wr_data_i[3:2], 2))
    else $error("bias corner wrong");
  a_clk_sleep: assert property (
    wr_en_i && wr_addr_i == 5'h06 |-> ##2
    {pll_ctrl_o.sleep, dll_ctrl_o.sleep} == $past(wr_data_i[1:0], 2))
    else $error("clock block sleep wrong");
  a_scale_steps: assert property (
    chan_a_ctrl_o.scale_steps == chan_a_ctrl_o.current_scale + 5'h01 &&
    chan_b_ctrl_o.scale_steps == chan_b_ctrl_o.current_scale + 5'h01)
    else $error("scale steps wrong");
  a_restart_hold: assert property (
    dll_ctrl_o.restart |-> dll_ctrl_o.filter_discharge && dll_ctrl_o.mid_bias)
    else $error("restart not holding loop");
  a_restart_lock: assert property (
    dll_ctrl_o.restart && $past(dll_ctrl_o.restart) |-> !dll_lock_o)
    else $error("lock shown during restart");
  a_delay_deg: assert property (
    dll_ctrl_o.delay_deg ==
    8'($signed(8'h5A) + $signed(8'h05) * $signed(dll_ctrl_o.delay_code)))
    else $error("delay degrees wrong");
  // Working offsets move only after a strobe write
  a_offset_sync: assert property (
    chan_a_offset_o != $past(chan_a_offset_o) || chan_b_offset_o != $past(chan_b_offset_o)
    |-> $past(wr_en_i && wr_addr_i == 5'h0C && wr_data_i[5], 2))
    else $error("offset changed without strobe");
  a_reset_dflt: assert property (
    $rose(rst_n_i) |-> chan_a_ctrl_o.current_scale == 4'hF && chan_a_offset_o == 13'h0000)
    else $error("defaults wrong after reset");
endmodule : cfg_bank_checker

bind dac_power_clock_offset_regs cfg_bank_checker u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i), .dll_lock_o(dll_lock_o), .chan_a_ctrl_o(chan_a_ctrl_o),
  .chan_b_ctrl_o(chan_b_ctrl_o), .dll_ctrl_o(dll_ctrl_o), .pll_ctrl_o(pll_ctrl_o),
  .chan_a_offset_o(chan_a_offset_o), .chan_b_offset_o(chan_b_offset_o));

// ===== dac_power_clock_offset_regs_test.sv
// Purpose: directed test of the converter config bank
// Assumes: host model issues one byte access at a time
// Notes: controls are checked three cycles after each write
module dac_power_clock_offset_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DFLT [10] = '{8'h0C, 8'hFF, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MASK [10] = '{8'h3F, 8'hFF, 8'h04, 8'hFF, 8'hFF,
                                       8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'hFF};
  localparam logic [4:0] MCODE [7] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h02};
  localparam logic [5:0] MVAL [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
  localparam logic [2:0] NCODE [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h5};
  localparam logic [3:0] NVAL [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  localparam logic [7:0] PWR [3] = '{8'h33, 8'h09, 8'h24};
  localparam logic [7:0] PT [2] = '{8'hF7, 8'h15};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic dll_lock_raw_i = 1'b0;
  logic wr_en_i, rd_en_i, rd_valid_o, dll_lock_o;
  logic [4:0] wr_addr_i, rd_addr_i;
  logic [7:0] wr_data_i, rd_data_o, rv;
  logic [12:0] ofa, ofb;
  dac_cfg_pkg::chan_ctrl_t ca, cb;
  dac_cfg_pkg::dll_ctrl_t dc;
  dac_cfg_pkg::pll_ctrl_t pc;
  int n_mismatch = 0;
  int num_checks = 0;
  bit ok;
  // Core clock, 10 ns period
  always #5 core_clk_i = ~core_clk_i;
  cfg_host_model host (.clk_i(core_clk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_en_o(rd_en_i),
    .rd_addr_o(rd_addr_i));
  dac_power_clock_offset_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .dll_lock_raw_i(dll_lock_raw_i), .dll_lock_o(dll_lock_o), .chan_a_ctrl_o(ca),
    .chan_b_ctrl_o(cb), .dll_ctrl_o(dc), .pll_ctrl_o(pc), .chan_a_offset_o(ofa),
    .chan_b_offset_o(ofb));
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Write, then give the decoded controls time to land
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    repeat (3) @(negedge core_clk_i);
  endtask : wr
  // A read that never answers ends the run
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    host.read_reg(a, rv, ok);
    if (!ok) begin
      n_mismatch++;
      complete_run();
    end else begin
      chk("read", exp, rv);
    end
  endtask : rd
  task automatic check_defaults();
    chk("dflt_lock", 1'h0, dll_lock_o);
    chk("dflt_chan", {2'h3, 5'h10, 5'h10}, {ca.bias_corner_sel, cb.bias_corner_sel,
      ca.scale_steps, cb.scale_steps});
    chk("dflt_clk", {8'h5A, 2'h1, 6'h01, 4'h1}, {dc.delay_deg, pc.post_div, pc.mult,
      pc.div});
    chk("dflt_ofs", {13'h0000, 13'h0000}, {ofa, ofb});
    for (int i = 0; i < 10; i++) begin
      rd(5'(i + 6), DFLT[i]);
    end
    rd(5'h1F, 8'h00);
  endtask : check_defaults
  // Main sequence
  initial begin
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check_defaults();
    // All ones everywhere, reserved bits must read back zero
    for (int i = 0; i < 10; i++) begin
      wr(5'(i + 6), 8'hFF);
      rd(5'(i + 6), MASK[i]);
    end
    wr(5'h1F, 8'hFF);
    rd(5'h1F, 8'h00);
    chk("ofs_first", {13'h1F00, 13'h0000}, {ofa, ofb});
    foreach (PWR[i]) begin
      wr(5'h06, PWR[i]);
      chk("pwr", PWR[i][5:0], {cb.sleep, ca.sleep, ca.bias_corner_sel, cb.bias_corner_sel,
        pc.sleep, dc.sleep});
    end
    wr(5'h07, 8'h3A);
    chk("gain", {4'h3, 5'h04, 4'hA, 5'h0B}, {ca.current_scale, ca.scale_steps,
      cb.current_scale, cb.scale_steps});
    for (int i = 0; i < 7; i++) begin
      wr(5'h09, {MCODE[i], NCODE[i % 5]});
      chk("mult", {i < 6, MVAL[i]}, {pc.mult_valid, pc.mult});
      chk("div", {(i % 5) < 4, NVAL[i % 5]}, {pc.div_valid, pc.div});
    end
    foreach (PT[i]) begin
      wr(5'h0B, PT[i]);
      chk("pll", {PT[i][7:6], PT[i][6] ? 2'h2 : 2'h1, PT[i][5:0]}, {pc.loop_filter_discharge,
        pc.oscillator_halving, pc.post_div, pc.gain, pc.range});
    end
    wr(5'h0A, 8'h8C);
    chk("dly", {8'h32, 1'h1, 3'h4, 1'h1}, {dc.delay_deg, dc.invclk, dc.ifixed,
      dc.ifixed_illegal});
    wr(5'h0A, 8'h75);
    chk("dly", {8'h7D, 1'h0, 3'h5, 1'h0}, {dc.delay_deg, dc.invclk, dc.ifixed,
      dc.ifixed_illegal});
    // Restart sequence after the delay change
    wr(5'h08, 8'h00);
    dll_lock_raw_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    chk("lock", 1'h1, dll_lock_o);
    wr(5'h08, 8'h04);
    chk("restart", 4'hE, {dc.restart, dc.filter_discharge, dc.mid_bias, dll_lock_o});
    wr(5'h08, 8'h00);
    repeat (3) @(negedge core_clk_i);
    chk("relock", 2'h1, {dc.restart, dll_lock_o});
    // Staged offsets wait for a fresh strobe edge
    wr(5'h0C, 8'h00);
    wr(5'h0D, 8'h34);
    wr(5'h0C, 8'h12);
    wr(5'h0E, 8'h05);
    wr(5'h0F, 8'h67);
    chk("ofs_hold", {13'h1F00, 13'h0000}, {ofa, ofb});
    wr(5'h0C, 8'h32);
    chk("ofs_load", {13'h1234, 13'h0567}, {ofa, ofb});
    wr(5'h0D, 8'h99);
    wr(5'h0C, 8'h32);
    chk("ofs_keep", {13'h1234, 13'h0567}, {ofa, ofb});
    rd(5'h0C, 8'h32);
    // Second reset in mid-run
    rst_n_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check_defaults();
    complete_run();
  end
endmodule : dac_power_clock_offset_regs_test

// ===== offset_hold.sv
// Purpose: working offset register loaded only on the transfer pulse
// Assumes: load_i is a one-cycle pulse from the same clock
// Notes: clears to zero on reset
module offset_hold #(
  parameter int W = 13
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] staged_i,
  output logic [W-1:0] held_o
);

  // Double buffer: staged writes never reach here directly
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_o <= '0;
    end else if (load_i) begin
      held_o <= staged_i;
    end
  end

endmodule : offset_hold

// ===== therm_decode.sv
// Purpose: decode a thermometer-coded divider field to its value
// Assumes: legal codes are zero or a run of ones from bit 0
// Notes: for a legal code the value equals the code plus one
module therm_decode #(
  parameter int CODE_W = 3
) (
  input wire logic [CODE_W-1:0] code_i,
  output logic [CODE_W:0] value_o,
  output logic valid_o
);

  logic [CODE_W:0] code_ext;
  logic [CODE_W:0] plus_one;

  // Run of ones plus one is a power of two
  always_comb begin
    code_ext = {1'b0, code_i};
    plus_one = code_ext + {{CODE_W{1'b0}}, 1'b1};
    valid_o = ((code_ext & plus_one) == '0);
    value_o = valid_o ? plus_one : '0;
  end

endmodule : therm_decode
